// [design/tcr_pkg.sv]
package tcr_pkg;

  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
  localparam logic [7:0] CMD_INPUT_VOLTAGE = 8'h88;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE = 8'h8b;
  localparam logic [7:0] CMD_DIODE_TEMPERATURE = 8'h8d;
  localparam logic [7:0] CMD_MAKER_ID = 8'h99;
  localparam logic [7:0] CMD_MODEL_ID = 8'h9a;
  localparam logic [7:0] CMD_REVISION_ID = 8'h9b;
  localparam logic [7:0] CMD_AUX_VOLTAGE = 8'hd0;
  localparam logic [7:0] CMD_CURRENT_SENSE = 8'hd1;
  localparam logic [7:0] CMD_INPUT_POWER = 8'hd2;
  localparam logic [7:0] CMD_CURRENT_LIMIT = 8'hd3;
  localparam logic [7:0] CMD_POWER_LIMIT = 8'hd4;
  localparam logic [7:0] CMD_PEAK_POWER = 8'hd5;
  localparam logic [7:0] CMD_CLEAR_PEAK = 8'hd6;

  // reset values and codes of the 12-bit readings
  localparam logic [11:0] READING_RESET = 12'h000;
  localparam logic [11:0] LIMIT_RESET = 12'hfff;
  localparam logic [11:0] LIMIT_DISABLED = 12'hfff;
  localparam logic [11:0] FULL_SCALE = 12'hfff;

  // block read byte counts
  localparam logic [7:0] MAKER_COUNT = 8'h03;
  localparam logic [7:0] MODEL_COUNT = 8'h08;
  localparam logic [7:0] REVISION_COUNT = 8'h02;

  // input status byte layout
  localparam int OC_WARN_BIT = 1;
  localparam int OP_WARN_BIT = 0;

  typedef enum logic [1:0] {
    TCR_READ,
    TCR_WRITE_WORD,
    TCR_SEND_BYTE,
    TCR_BLOCK_READ
  } tcr_kind_type;

  typedef struct packed {
    logic [11:0] vin;
    logic [11:0] vout;
    logic [11:0] temp;
    logic [11:0] iin;
    logic signed [13:0] aux;
  } tcr_sample_type;

  typedef struct packed {
    tcr_kind_type kind;
    logic [7:0] code;
    logic [3:0] index;
    logic [15:0] wdata;
  } tcr_req_type;

  typedef struct packed {
    logic [15:0] data;
    logic last;
    logic error;
  } tcr_rsp_type;

endpackage

// [design/tcr_telemetry_regs.sv]
// Overview of operation
// - input voltage reads as 12-bit word at 88h, zero after reset
// - the reported input voltage sample feeds the voltage warning compare
// - output voltage reads as 12-bit word at 8Bh, zero after reset
// - the reported output voltage sample feeds the output under-voltage compare
// - diode temperature reads as a signed word at 8Dh
// - reported temperature feeds temperature compares, span -256 to +255 C
// - block read 99h: count 3 then three maker bytes
// - block read 9Ah: count 8 then eight model bytes, last two zero
// - block read 9Bh: count 2 then two revision bytes
// - auxiliary converter result reads as 12-bit word at D0h
// - auxiliary reading saturates at full scale at or above top of range
// - auxiliary reading is zero at or below zero volts
// - current-sense reading at D1h, zero after reset
// - input power at D2h is upper 12 bits of voltage times current
// - current above limit D3h sets over-current flag and alert line
// - current limit is read/write, resets to 0FFFh, 0FFFh disables
// - power above limit D4h sets over-power flag and alert line
// - power limit is read/write, resets to 0FFFh, 0FFFh disables
// - D5h holds peak input power since reset or clear, starts zero
// - send byte D6h clears the stored peak to zero
// - flags stay set until condition gone and clear-faults is issued
// - input status byte: over-current warn bit 1, over-power warn bit 0
module tcr_telemetry_regs #(
  parameter logic [23:0] MAKER_ID = 24'h111213, // arbitrary value
  parameter logic [47:0] MODEL_ID = 48'h212223242526, // arbitrary value
  parameter logic [15:0] REVISION_ID = 16'h3132, // arbitrary value
  parameter logic signed [13:0] AUX_FULL_CODE = 14'sh0fff
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // converter samples
  input wire logic smp_valid,
  input wire tcr_pkg::tcr_sample_type smp,
  // command port from the protocol engine
  input wire logic req_valid,
  input wire tcr_pkg::tcr_req_type req,
  output tcr_pkg::tcr_rsp_type rsp,
  output logic rsp_valid,
  // samples for the voltage and temperature comparators
  output logic [11:0] vin_compare,
  output logic [11:0] vout_compare,
  output logic [11:0] temp_compare,
  // open-drain alert pin
  input wire logic alert_line_i,
  output logic alert_line_o,
  output logic alert_line_oe_n
);

  logic [11:0] vin_reading;
  logic [11:0] vout_reading;
  logic [11:0] temp_reading;
  logic [11:0] aux_reading;
  logic [11:0] iin_reading;
  logic [11:0] power_reading;
  logic [11:0] peak_reading;
  logic [11:0] current_limit;
  logic [11:0] power_limit;
  logic oc_flag;
  logic op_flag;
  logic [2:0] alert_sync;

  // decode of the request
  wire is_read = req_valid && req.kind == tcr_pkg::TCR_READ;
  wire is_write = req_valid && req.kind == tcr_pkg::TCR_WRITE_WORD;
  wire is_send = req_valid && req.kind == tcr_pkg::TCR_SEND_BYTE;
  wire is_block = req_valid && req.kind == tcr_pkg::TCR_BLOCK_READ;
  wire wr_current_limit = is_write && req.code == tcr_pkg::CMD_CURRENT_LIMIT;
  wire wr_power_limit = is_write && req.code == tcr_pkg::CMD_POWER_LIMIT;
  wire clear_peak = is_send && req.code == tcr_pkg::CMD_CLEAR_PEAK;
  wire clear_faults = is_send && req.code == tcr_pkg::CMD_CLEAR_FAULTS;

  // converter front end
  wire [23:0] product = smp.vin * smp.iin;
  wire [11:0] next_power = product[23:12];
  wire aux_low = smp.aux <= 14'sh0000;
  wire aux_high = smp.aux >= AUX_FULL_CODE;
  wire [11:0] next_aux = aux_low ? 12'h000 :
                         aux_high ? tcr_pkg::FULL_SCALE :
                         smp.aux[11:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vin_reading <= tcr_pkg::READING_RESET;
      vout_reading <= tcr_pkg::READING_RESET;
      temp_reading <= tcr_pkg::READING_RESET;
      aux_reading <= tcr_pkg::READING_RESET;
      iin_reading <= tcr_pkg::READING_RESET;
      power_reading <= tcr_pkg::READING_RESET;
    end else if (smp_valid) begin
      vin_reading <= smp.vin;
      vout_reading <= smp.vout;
      temp_reading <= smp.temp;
      aux_reading <= next_aux;
      iin_reading <= smp.iin;
      power_reading <= next_power;
    end
  end

  // comparators outside read the very words that the host reads
  assign vin_compare = vin_reading;
  assign vout_compare = vout_reading;
  assign temp_compare = temp_reading;

  // peak tracker; a clear and a larger sample in one cycle: the clear wins,
  // the next cycle picks the standing power word up again
  wire peak_rise = power_reading > peak_reading;
  wire [11:0] next_peak = clear_peak ? tcr_pkg::READING_RESET :
                          peak_rise ? power_reading :
                          peak_reading;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      peak_reading <= tcr_pkg::READING_RESET;
    end else begin
      peak_reading <= next_peak;
    end
  end

  // warning limits; upper bits of a written word are dropped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      current_limit <= tcr_pkg::LIMIT_RESET;
      power_limit <= tcr_pkg::LIMIT_RESET;
    end else begin
      if (wr_current_limit) begin
        current_limit <= req.wdata[11:0];
      end
      if (wr_power_limit) begin
        power_limit <= req.wdata[11:0];
      end
    end
  end

  // compares run on the registered readings, so a flag follows a sample
  // by two cycles and never looks at a half-updated word
  wire oc_cond = current_limit != tcr_pkg::LIMIT_DISABLED &&
                 iin_reading > current_limit;
  wire op_cond = power_limit != tcr_pkg::LIMIT_DISABLED &&
                 power_reading > power_limit;
  // a live condition beats a clear in the same cycle
  wire next_oc = oc_cond || (oc_flag && !clear_faults);
  wire next_op = op_cond || (op_flag && !clear_faults);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oc_flag <= 1'b0;
      op_flag <= 1'b0;
      alert_line_o <= 1'b0;
      alert_line_oe_n <= 1'b1;
      alert_sync <= 3'h7;
    end else begin
      oc_flag <= next_oc;
      op_flag <= next_op;
      alert_line_o <= 1'b0;
      alert_line_oe_n <= !(next_oc || next_op);
      alert_sync <= {alert_sync[1:0], alert_line_i};
    end
  end

  // pin read back through three stages; it only counts as low once the
  // last two agree, since the wire is shared and moves off our clock
  wire alert_pin_low = !alert_sync[1] && !alert_sync[2];

  // block read bytes: count first, then identity bytes, high byte first
  wire [31:0] maker_block = {tcr_pkg::MAKER_COUNT, MAKER_ID};
  wire [71:0] model_block = {tcr_pkg::MODEL_COUNT, MODEL_ID, 16'h0000};
  wire [23:0] rev_block = {tcr_pkg::REVISION_COUNT, REVISION_ID};
  wire [6:0] byte_shift = {req.index, 3'b000};
  wire [31:0] maker_sel = maker_block << byte_shift;
  wire [71:0] model_sel = model_block << byte_shift;
  wire [23:0] rev_sel = rev_block << byte_shift;
  wire [7:0] req_index8 = {4'h0, req.index};
  wire blk_maker = req.code == tcr_pkg::CMD_MAKER_ID;
  wire blk_model = req.code == tcr_pkg::CMD_MODEL_ID;
  wire blk_rev = req.code == tcr_pkg::CMD_REVISION_ID;
  wire [7:0] blk_byte = blk_maker ? maker_sel[31:24] :
                        blk_model ? model_sel[71:64] :
                        blk_rev ? rev_sel[23:16] : 8'h00;
  wire [7:0] blk_count = blk_maker ? tcr_pkg::MAKER_COUNT :
                         blk_model ? tcr_pkg::MODEL_COUNT :
                         tcr_pkg::REVISION_COUNT;
  wire blk_known = blk_maker || blk_model || blk_rev;
  wire blk_over = req_index8 > blk_count;

  // word read mux; temperature is sign extended
  wire [7:0] status_byte = {6'h00, oc_flag, op_flag};
  wire [15:0] temp_word = {{4{temp_reading[11]}}, temp_reading};
  wire [15:0] read_word =
    req.code == tcr_pkg::CMD_INPUT_VOLTAGE ? {4'h0, vin_reading} :
    req.code == tcr_pkg::CMD_OUTPUT_VOLTAGE ? {4'h0, vout_reading} :
    req.code == tcr_pkg::CMD_DIODE_TEMPERATURE ? temp_word :
    req.code == tcr_pkg::CMD_AUX_VOLTAGE ? {4'h0, aux_reading} :
    req.code == tcr_pkg::CMD_CURRENT_SENSE ? {4'h0, iin_reading} :
    req.code == tcr_pkg::CMD_INPUT_POWER ? {4'h0, power_reading} :
    req.code == tcr_pkg::CMD_CURRENT_LIMIT ? {4'h0, current_limit} :
    req.code == tcr_pkg::CMD_POWER_LIMIT ? {4'h0, power_limit} :
    req.code == tcr_pkg::CMD_PEAK_POWER ? {4'h0, peak_reading} :
    {8'h00, status_byte};
  wire read_known =
    req.code == tcr_pkg::CMD_INPUT_VOLTAGE ||
    req.code == tcr_pkg::CMD_OUTPUT_VOLTAGE ||
    req.code == tcr_pkg::CMD_DIODE_TEMPERATURE ||
    req.code == tcr_pkg::CMD_AUX_VOLTAGE ||
    req.code == tcr_pkg::CMD_CURRENT_SENSE ||
    req.code == tcr_pkg::CMD_INPUT_POWER ||
    req.code == tcr_pkg::CMD_CURRENT_LIMIT ||
    req.code == tcr_pkg::CMD_POWER_LIMIT ||
    req.code == tcr_pkg::CMD_PEAK_POWER ||
    req.code == tcr_pkg::CMD_INPUT_STATUS;

  wire req_error = (is_read && !read_known) ||
                   (is_block && (!blk_known || blk_over)) ||
                   (is_write && !(wr_current_limit || wr_power_limit)) ||
                   (is_send && !(clear_peak || clear_faults));
  wire [15:0] next_data = is_read ? read_word :
                          is_block ? {8'h00, blk_byte} : 16'h0000;
  wire next_last = is_block && blk_known && req_index8 == blk_count;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
      rsp <= '{data: next_data, last: next_last, error: req_error};
    end
  end

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_power_product: assert property (
    smp_valid |=> power_reading == $past(product[23:12]))
    else $error("power word is not the upper product bits");
  chk_oc_raise: assert property (
    (current_limit != 12'hfff && iin_reading > current_limit)
      |=> oc_flag && !alert_line_oe_n)
    else $error("over-current did not raise flag and alert");
  chk_oc_disabled: assert property (
    (current_limit == 12'hfff && !oc_flag && !op_flag) |=> !oc_flag)
    else $error("disabled current limit raised a flag");
  chk_op_raise: assert property (
    (power_limit != 12'hfff && power_reading > power_limit) |=> op_flag)
    else $error("over-power did not raise flag");
  chk_peak_hold: assert property (
    !clear_peak |=> peak_reading >= $past(power_reading))
    else $error("peak fell below a seen power word");
  chk_peak_clear: assert property (
    clear_peak |=> peak_reading == 12'h000)
    else $error("peak not cleared");
  chk_flag_sticky: assert property (
    (oc_flag && !clear_faults) |=> oc_flag)
    else $error("over-current flag dropped without clear");
  chk_alert_level: assert property (
    (oc_flag || op_flag) == !alert_line_oe_n)
    else $error("alert line disagrees with flags");
  chk_aux_floor: assert property (
    (smp_valid && smp.aux <= 14'sh0000) |=> aux_reading == 12'h000)
    else $error("auxiliary reading not zero at floor");
  chk_maker_count: assert property (
    (is_block && blk_maker && req.index == 4'h0)
      |=> rsp_valid && rsp.data == 16'h0003 && !rsp.error)
    else $error("maker block count wrong");

  // every taken sample lands in the words the host reads
  chk_vin_compare: assert property (
    smp_valid |=> vin_compare == $past(smp.vin))
    else $error("input voltage compare word missed a sample");
  chk_vout_compare: assert property (
    smp_valid |=> vout_compare == $past(smp.vout))
    else $error("output voltage compare word missed a sample");
  chk_temp_compare: assert property (
    smp_valid |=> temp_compare == $past(smp.temp))
    else $error("temperature compare word missed a sample");
  chk_iin_sample: assert property (
    smp_valid |=> iin_reading == $past(smp.iin))
    else $error("current-sense reading missed a sample");
  chk_aux_ceiling: assert property (
    (smp_valid && smp.aux >= AUX_FULL_CODE)
      |=> aux_reading == tcr_pkg::FULL_SCALE)
    else $error("auxiliary reading not at full scale");
  chk_aux_pass: assert property (
    (smp_valid && smp.aux > 14'sh0000 && smp.aux < AUX_FULL_CODE)
      |=> aux_reading == $past(smp.aux[11:0]))
    else $error("auxiliary reading lost the converter code");

  // word reads answer a cycle later with the word standing at the request
  chk_vin_word: assert property (
    (is_read && req.code == tcr_pkg::CMD_INPUT_VOLTAGE)
      |=> rsp_valid && rsp.data == {4'h0, $past(vin_reading)})
    else $error("input voltage read returned the wrong word");
  chk_vout_word: assert property (
    (is_read && req.code == tcr_pkg::CMD_OUTPUT_VOLTAGE)
      |=> rsp_valid && rsp.data == {4'h0, $past(vout_reading)})
    else $error("output voltage read returned the wrong word");
  chk_temp_word: assert property (
    (is_read && req.code == tcr_pkg::CMD_DIODE_TEMPERATURE)
      |=> rsp.data == {{4{$past(temp_reading[11])}}, $past(temp_reading)})
    else $error("temperature read not the sign-extended reading");
  chk_aux_word: assert property (
    (is_read && req.code == tcr_pkg::CMD_AUX_VOLTAGE)
      |=> rsp_valid && rsp.data == {4'h0, $past(aux_reading)})
    else $error("auxiliary read returned the wrong word");
  chk_iin_word: assert property (
    (is_read && req.code == tcr_pkg::CMD_CURRENT_SENSE)
      |=> rsp_valid && rsp.data == {4'h0, $past(iin_reading)})
    else $error("current-sense read returned the wrong word");
  chk_power_word: assert property (
    (is_read && req.code == tcr_pkg::CMD_INPUT_POWER)
      |=> rsp_valid && rsp.data == {4'h0, $past(power_reading)})
    else $error("input power read returned the wrong word");
  chk_peak_word: assert property (
    (is_read && req.code == tcr_pkg::CMD_PEAK_POWER)
      |=> rsp_valid && rsp.data == {4'h0, $past(peak_reading)})
    else $error("peak power read returned the wrong word");
  chk_climit_word: assert property (
    (is_read && req.code == tcr_pkg::CMD_CURRENT_LIMIT)
      |=> rsp_valid && rsp.data == {4'h0, $past(current_limit)})
    else $error("current limit read returned the wrong word");
  chk_status_word: assert property (
    (is_read && req.code == tcr_pkg::CMD_INPUT_STATUS)
      |=> rsp.data == {14'h0000, $past(oc_flag), $past(op_flag)})
    else $error("input status byte has the wrong layout");

  // limit words and the strict compare against them
  chk_climit_write: assert property (
    wr_current_limit |=> current_limit == $past(req.wdata[11:0]))
    else $error("current limit did not take the written word");
  chk_plimit_write: assert property (
    wr_power_limit |=> power_limit == $past(req.wdata[11:0]))
    else $error("power limit did not take the written word");
  chk_op_disabled: assert property (
    (power_limit == tcr_pkg::LIMIT_DISABLED && !op_flag) |=> !op_flag)
    else $error("disabled power limit raised a flag");
  chk_oc_equal: assert property (
    (iin_reading <= current_limit && !oc_flag) |=> !oc_flag)
    else $error("current at or below limit raised a flag");
  chk_op_equal: assert property (
    (power_reading <= power_limit && !op_flag) |=> !op_flag)
    else $error("power at or below limit raised a flag");
  chk_op_alert: assert property (
    (power_limit != tcr_pkg::LIMIT_DISABLED && power_reading > power_limit)
      |=> !alert_line_oe_n)
    else $error("over-power did not pull the alert line");

  // a clear only lands once the condition behind the flag has gone
  chk_op_sticky: assert property (
    (op_flag && !clear_faults) |=> op_flag)
    else $error("over-power flag dropped without clear");
  chk_oc_cleared: assert property (
    (clear_faults && !oc_cond) |=> !oc_flag)
    else $error("over-current flag survived a clear");
  chk_op_cleared: assert property (
    (clear_faults && !op_cond) |=> !op_flag)
    else $error("over-power flag survived a clear");

  // identity blocks: counts, zero tail, last marker and overrun
  chk_model_count: assert property (
    (is_block && blk_model && req.index == 4'h0)
      |=> rsp.data == {8'h00, tcr_pkg::MODEL_COUNT} && !rsp.error)
    else $error("model block count wrong");
  chk_model_tail: assert property (
    (is_block && blk_model && req.index inside {4'h7, 4'h8})
      |=> rsp.data == 16'h0000 && !rsp.error)
    else $error("model block tail bytes not zero");
  chk_rev_count: assert property (
    (is_block && blk_rev && req.index == 4'h0)
      |=> rsp.data == {8'h00, tcr_pkg::REVISION_COUNT} && !rsp.error)
    else $error("revision block count wrong");
  chk_rev_over: assert property (
    (is_block && blk_rev && req.index == 4'h3) |=> rsp.error && !rsp.last)
    else $error("revision block read past its end was not refused");
  chk_maker_last: assert property (
    (is_block && blk_maker && req.index == 4'h3) |=> rsp.last && !rsp.error)
    else $error("maker block did not mark its last byte");

  // the shared pin must read back low while this block pulls it
  chk_alert_pin: assert property (
    (!alert_line_oe_n) [*4] |-> alert_pin_low)
    else $error("alert pin did not read back low");

endmodule

// [tb/tcr_host_model.sv]
module tcr_host_model (
  // clock
  input wire logic mclk,
  // requests toward the block
  output logic req_valid,
  output tcr_pkg::tcr_req_type req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // released fields are scrambled so nothing leans on stale values
  task automatic issue(input tcr_pkg::tcr_kind_type k, input logic [7:0] c,
      input logic [3:0] i, input logic [15:0] w);
    @(negedge mclk);
    req_valid = 1'b1;
    req = '{kind: k, code: c, index: i, wdata: w};
    @(negedge mclk);
    req_valid = 1'b0;
    req = tcr_pkg::tcr_req_type'(~req);
  endtask
endmodule

// [tb/tcr_telemetry_regs_tb.sv]
module tcr_telemetry_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [23:0] MAKER = 24'h5a6b7c; // arbitrary value
  localparam logic [47:0] MODEL = 48'ha1b2c3d4e5f6; // arbitrary value
  localparam logic [15:0] REV = 16'h7e8f; // arbitrary value
  localparam logic signed [13:0] AUX_TOP = 14'sh0fff;
  logic mclk, rst_n, smp_valid, req_valid, rsp_valid;
  logic alert_line_o, alert_line_oe_n;
  logic [11:0] vin_compare, vout_compare, temp_compare, peak;
  tcr_pkg::tcr_sample_type smp;
  tcr_pkg::tcr_req_type req;
  tcr_pkg::tcr_rsp_type rsp;
  tcr_pkg::tcr_rsp_type exp_q[$];
  logic [1:0] mode_q[$];
  logic [7:0] rc[10] = '{8'h88, 8'h8b, 8'h8d, 8'hd0, 8'hd1, 8'hd2, 8'hd5,
    8'hd3, 8'hd4, 8'h7c};
  logic signed [13:0] ab[4] = '{14'sh0, 14'sh3fff, 14'sh0ffe, 14'sh0fff};
  int n_errors = 0;
  int n_compared = 0;
  // pull-up on the shared alert wire
  wire logic alert_line_i = alert_line_oe_n ? 1'b1 : alert_line_o;

  tcr_telemetry_regs #(.MAKER_ID(MAKER), .MODEL_ID(MODEL),
    .REVISION_ID(REV), .AUX_FULL_CODE(AUX_TOP)) DUT (.mclk(mclk),
    .rst_n(rst_n), .smp_valid(smp_valid), .smp(smp),
    .req_valid(req_valid), .req(req), .rsp(rsp), .rsp_valid(rsp_valid),
    .vin_compare(vin_compare), .vout_compare(vout_compare),
    .temp_compare(temp_compare), .alert_line_i(alert_line_i),
    .alert_line_o(alert_line_o), .alert_line_oe_n(alert_line_oe_n));
  tcr_host_model host (.mclk(mclk), .req_valid(req_valid), .req(req));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] g, e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask

  // mode 0: data and error, 1: also last, 2: error only
  always @(negedge mclk) begin
    tcr_pkg::tcr_rsp_type e;
    logic [1:0] m;
    if (rsp_valid === 1'b1 && exp_q.size() == 0) begin
      n_errors++;
      $display("[FAIL] %0t response with no request", $time);
    end else if (rsp_valid === 1'b1) begin
      e = exp_q.pop_front();
      m = mode_q.pop_front();
      check({15'h0, rsp.error}, {15'h0, e.error});
      if (m != 2'd2)
        check(rsp.data, e.data);
      if (m == 2'd1)
        check({15'h0, rsp.last}, {15'h0, e.last});
    end
  end

  task automatic ask(input tcr_pkg::tcr_kind_type k, input logic [7:0] c,
      input logic [3:0] i, input logic [15:0] w, d, input logic er, la,
      input logic [1:0] m);
    exp_q.push_back('{data: d, last: la, error: er});
    mode_q.push_back(m);
    host.issue(k, c, i, w);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] d);
    ask(tcr_pkg::TCR_READ, c, 4'h0, 16'h0, d, 1'b0, 1'b0, 2'd0);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] w, input logic er);
    ask(tcr_pkg::TCR_WRITE_WORD, c, 4'h0, w, 16'h0, er, 1'b0, 2'd2);
  endtask
  task automatic sb(input logic [7:0] c, input logic er);
    ask(tcr_pkg::TCR_SEND_BYTE, c, 4'h0, 16'h0, 16'h0, er, 1'b0, 2'd2);
    repeat (2) @(negedge mclk);
  endtask
  task automatic alert(input logic a);
    check({15'h0, alert_line_oe_n}, {15'h0, ~a});
    check({15'h0, alert_line_o}, 16'h0000);
  endtask

  task automatic apply(input logic [11:0] vi, vo, t, ii,
      input logic signed [13:0] ax);
    logic [23:0] p;
    logic [11:0] a;
    @(negedge mclk);
    smp = '{vin: vi, vout: vo, temp: t, iin: ii, aux: ax};
    smp_valid = 1'b1;
    @(negedge mclk);
    smp_valid = 1'b0;
    repeat (2) @(negedge mclk);
    p = vi * ii;
    if (p[23:12] > peak)
      peak = p[23:12];
    a = (ax <= 0) ? 12'h000 : (ax >= AUX_TOP) ? 12'hfff : ax[11:0];
    check({4'h0, vin_compare}, {4'h0, vi});
    check({4'h0, vout_compare}, {4'h0, vo});
    check({4'h0, temp_compare}, {4'h0, t});
    rd(8'h88, {4'h0, vi});
    rd(8'h8b, {4'h0, vo});
    rd(8'h8d, {{4{t[11]}}, t});
    rd(8'hd0, {4'h0, a});
    rd(8'hd1, {4'h0, ii});
    rd(8'hd2, {4'h0, p[23:12]});
    rd(8'hd5, {4'h0, peak});
  endtask

  // the first sample sits exactly on the limit, the second just above it
  task automatic warn(input logic [7:0] c, input logic [11:0] lim,
      input logic [11:0] vi, ie, ih, input logic [7:0] st);
    wr(c, {4'h0, lim}, 1'b0);
    rd(c, {4'h0, lim});
    apply(vi, 12'h0, 12'h0, ie, 14'sh0);
    alert(1'b0);
    apply(vi, 12'h0, 12'h0, ih, 14'sh0);
    alert(1'b1);
    rd(8'h7c, {8'h0, st});
    sb(8'h03, 1'b0);
    alert(1'b1);
    apply(12'h0, 12'h0, 12'h0, 12'h0, 14'sh0);
    alert(1'b1);
    sb(8'h03, 1'b0);
    alert(1'b0);
    rd(8'h7c, 16'h0);
    wr(c, 16'h0fff, 1'b0);
  endtask

  task automatic block(input logic [7:0] c, n, input logic [63:0] b);
    for (int i = 0; i <= n + 1; i++)
      ask(tcr_pkg::TCR_BLOCK_READ, c, i[3:0], 16'h0,
        (i == 0) ? {8'h0, n} : (i > n) ? 16'h0 : {8'h0, b[71 - 8 * i -: 8]},
        i > n, i == n, 2'd1);
  endtask

  task automatic summarize();
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("[FAIL] %0t responses missing", $time);
    end
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    $display("[FAIL] %0t watchdog", $time);
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    smp_valid = 1'b0;
    smp = '0;
    peak = 12'h0;
    void'($urandom(32'h54a0));
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    alert(1'b0);
    foreach (rc[i])
      rd(rc[i], (i inside {7, 8}) ? 16'h0fff : 16'h0);
    repeat (6)
      apply(12'($urandom), 12'($urandom), 12'($urandom), 12'($urandom),
        14'($urandom));
    foreach (ab[i])
      apply(12'h0, 12'h0, 12'h800, 12'h0, ab[i]);
    warn(8'hd3, 12'h400, 12'h010, 12'h400, 12'h401, 8'h02);
    warn(8'hd4, 12'h100, 12'h800, 12'h200, 12'h202, 8'h01);
    sb(8'hd6, 1'b0);
    peak = 12'h0;
    rd(8'hd5, 16'h0);
    apply(12'h100, 12'h0, 12'h0, 12'h100, 14'sh0);
    // refused requests must leave the input voltage reading at 88h untouched
    ask(tcr_pkg::TCR_READ, 8'h00, 4'h0, 16'h0, 16'h0, 1'b1, 1'b0, 2'd0);
    wr(8'h88, 16'h0123, 1'b1);
    sb(8'h55, 1'b1);
    rd(8'h88, 16'h0100);
    block(8'h99, 8'h03, {MAKER, 40'h0});
    block(8'h9a, 8'h08, {MODEL, 16'h0});
    block(8'h9b, 8'h02, {REV, 48'h0});
    repeat (4) @(negedge mclk);
    summarize();
  end
endmodule
